// ==== hw/bccp_pkg.sv ====
package bccp_pkg;
  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;               // system clock rate
  localparam int MIN_ON_NS = 1500;                // least conduction time
  localparam int MIN_ON_CYC = (MIN_ON_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DT_NS = 1000;                    // guard time between switches
  localparam int DT_CYC = (DT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int BLANK_NS = 1000;                 // comparator mask interval
  localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int OFF_NS = 5600;                   // default off-timer length
  localparam int OFF_CYC = (OFF_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int OCD_ON_CYC = 2;                  // detector assert delay
  localparam int OCD_OFF_CYC = 2;                 // detector release delay
  localparam int EN_OFF_CYC = 2;                  // enable-off delay
  localparam int EN_ON_CYC = 2;                   // enable-on delay

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;       // enable, drive phase
  localparam logic [7:0] ADDR_OFFT = 8'h04;       // off-timer cycles
  localparam logic [7:0] ADDR_DT = 8'h08;         // guard time cycles
  localparam logic [7:0] ADDR_BLANK = 8'h0c;      // mask cycles
  localparam logic [7:0] ADDR_MINON = 8'h10;      // least on cycles
  localparam logic [7:0] ADDR_STAT = 8'h14;       // read-only status
  localparam int CTRL_SW_EN = 0;                  // software drive enable
  localparam int CTRL_HI_LSB = 4;                 // high leg index
  localparam int CTRL_LO_LSB = 6;                 // low leg index
  localparam logic [15:0] OFFT_RST = 16'(OFF_CYC);
  localparam logic [7:0] DT_RST = 8'(DT_CYC);
  localparam logic [7:0] BLANK_RST = 8'(BLANK_CYC);
  localparam logic [7:0] MINON_RST = 8'(MIN_ON_CYC);
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    BCCP_OFF = 3'h0,     // all switches off
    BCCP_ON = 3'h1,      // conduction
    BCCP_DT1 = 3'h3,     // low side off, guard time
    BCCP_SYNC = 3'h2,    // synchronous rectification
    BCCP_DT2 = 3'h6      // high rectifier off, guard time
  } bccp_state_e;

  typedef struct packed {
    logic [2:0] hi;      // high-side gates
    logic [2:0] lo;      // low-side gates
  } bccp_gate_s;

  typedef struct packed {
    logic [15:0] off_cyc;
    logic [7:0] dt_cyc;
    logic [7:0] blank_cyc;
    logic [7:0] minon_cyc;
  } bccp_cfg_s;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } bccp_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } bccp_axi_rsp_s;
endpackage : bccp_pkg

// ==== hw/bccp_protect.sv ====
`timescale 1ns/1ps
`default_nettype none
module bccp_protect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ovc_12,
  input wire logic ovc_3,
  input wire logic temp_hi,
  input wire logic temp_lo,
  input wire logic any_on,
  input wire logic enable_in,
  output logic fault_n_oe,
  output logic bridge_allow,
  output logic ovt_active
);
  import bccp_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ocd_cnt;   // detector delay counter
    logic ocd_drv;         // detector pulling fault low
    logic overtemperature_detector;             // overtemperature latched
    logic [3:0] en_cnt;    // enable filter counter
    logic en_ok;           // enable accepted
  } bccp_prot_s;

  bccp_prot_s s_r;
  bccp_prot_s s_nxt;
  logic ocd_raw;

  // combined-current or bridge-three detection
  assign ocd_raw = ovc_12 | ovc_3;

  // next state
  always_comb begin
    s_nxt = s_r;
    if (!s_r.ocd_drv) begin
      // assert after detection delay
      if (ocd_raw) begin
        s_nxt.ocd_cnt = s_r.ocd_cnt + 4'h1;
        if (s_r.ocd_cnt == 4'(OCD_ON_CYC - 1)) begin
          s_nxt.ocd_drv = 1'b1;
          s_nxt.ocd_cnt = 4'h0;
        end
      end else begin
        s_nxt.ocd_cnt = 4'h0;
      end
    end else begin
      // release once nothing conducts and no current
      if (!ocd_raw && !any_on) begin
        s_nxt.ocd_cnt = s_r.ocd_cnt + 4'h1;
        if (s_r.ocd_cnt == 4'(OCD_OFF_CYC - 1)) begin
          s_nxt.ocd_drv = 1'b0;
          s_nxt.ocd_cnt = 4'h0;
        end
      end else begin
        s_nxt.ocd_cnt = 4'h0;
      end
    end
    // thermal hysteresis
    if (temp_hi) begin
      s_nxt.overtemperature_detector = 1'b1;
    end else if (!temp_lo) begin
      s_nxt.overtemperature_detector = 1'b0;
    end
    // enable delays in both directions
    if (enable_in != s_r.en_ok) begin
      s_nxt.en_cnt = s_r.en_cnt + 4'h1;
      if (s_r.en_ok && s_r.en_cnt == 4'(EN_OFF_CYC - 1)) begin
        s_nxt.en_ok = 1'b0;
        s_nxt.en_cnt = 4'h0;
      end else if (!s_r.en_ok && s_r.en_cnt == 4'(EN_ON_CYC - 1)) begin
        s_nxt.en_ok = 1'b1;
        s_nxt.en_cnt = 4'h0;
      end
    end else begin
      s_nxt.en_cnt = 4'h0;
    end
  end

  // register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fault_n_oe = ~(s_r.ocd_drv | s_r.overtemperature_detector);
  assign bridge_allow = s_r.en_ok & ~s_r.overtemperature_detector;
  assign ovt_active = s_r.overtemperature_detector;
endmodule : bccp_protect
`default_nettype wire

// ==== hw/bccp_top.sv ====
// Overview of operation
// - every on interval lasts at least minimum time; a filtered enable loss or overtemperature ends it early
// - short on-times tolerated, off-time stays fixed
// - only two legs driven, third fully off
// - off interval starts by dropping low side
// - after guard time, high side rectifies
// - off-timer end: high off, guard, low on
// - early trip waits for minimum on-time
// - overcurrent from bridges one+two or three
// - after detect delay, pull fault low
// - enable low switches all off after delay
// - idle bridge releases fault after delay
// - enable high resumes after delay
// - overtemperature forces fault and shutdown
// - release below lower threshold, then restart
// - current over reference starts off interval
// - comparator ignored during blanking after turn-on
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bccp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bccp_pkg::bccp_axi_req_s axi_req,
  output bccp_pkg::bccp_axi_rsp_s axi_rsp,
  input wire logic sense_trip,
  input wire logic ovc_12,
  input wire logic ovc_3,
  input wire logic temp_hi,
  input wire logic temp_lo,
  input wire logic enable_in,
  output bccp_pkg::bccp_gate_s gates,
  output logic fault_open_drain_output_o,
  output logic fault_open_drain_output_oe
);
  import bccp_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    bccp_state_e st;         // chopper state
    logic [15:0] cnt;        // interval counter
    logic [7:0] on_cnt;      // on-time counter
    logic trip_pend;         // trip seen before minimum
    bccp_gate_s g;           // gate outputs
    logic sw_en;             // software enable
    logic [1:0] hi_leg;      // high leg select
    logic [1:0] lo_leg;      // low leg select
    bccp_cfg_s cfg;          // interval lengths
    logic aw_got;            // write address held
    logic w_got;             // write data held
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    bccp_axi_rsp_s rsp;      // bus outputs
    logic [7:0] trips;       // chop cycle count
  } bccp_top_s;

  bccp_top_s s_r;
  bccp_top_s s_nxt;
  logic allow;
  logic fault_oe;
  logic overtemperature_detector;
  logic any_on;
  logic run;
  logic [31:0] wmask;
  logic [31:0] rd;

  // ---------------------------------------------------------------------------
  // protection
  // ---------------------------------------------------------------------------
  bccp_protect u_prot (
    .aclk(aclk),
    .aresetn(aresetn),
    .ovc_12(ovc_12),
    .ovc_3(ovc_3),
    .temp_hi(temp_hi),
    .temp_lo(temp_lo),
    .any_on(any_on),
    .enable_in(enable_in),
    .fault_n_oe(fault_oe),
    .bridge_allow(allow),
    .ovt_active(overtemperature_detector)
  );

  assign any_on = |{s_r.g.hi, s_r.g.lo};
  // legs must differ for a valid drive
  assign run = allow & s_r.sw_en & (s_r.hi_leg != s_r.lo_leg) & (s_r.hi_leg != 2'h3) & (s_r.lo_leg != 2'h3);

  // byte-lane mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_r.w_strb[i]}};
    end
  end

  // read data mux
  always_comb begin
    rd = 32'h0;
    unique case (axi_req.araddr)
      ADDR_CTRL: begin
        rd[CTRL_SW_EN] = s_r.sw_en;
        rd[CTRL_HI_LSB +: 2] = s_r.hi_leg;
        rd[CTRL_LO_LSB +: 2] = s_r.lo_leg;
      end
      ADDR_OFFT: rd[15:0] = s_r.cfg.off_cyc;
      ADDR_DT: rd[7:0] = s_r.cfg.dt_cyc;
      ADDR_BLANK: rd[7:0] = s_r.cfg.blank_cyc;
      ADDR_MINON: rd[7:0] = s_r.cfg.minon_cyc;
      ADDR_STAT: rd = {16'h0, s_r.trips, 1'b0, overtemperature_detector, ~fault_oe, allow, 1'b0, s_r.st};
      default: rd = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] nv;
    nv = 32'h0;
    s_nxt = s_r;
    // bus handshakes
    s_nxt.rsp.awready = 1'b0;
    s_nxt.rsp.wready = 1'b0;
    s_nxt.rsp.arready = 1'b0;
    if (axi_req.awvalid && !s_r.aw_got && !s_r.rsp.awready && !s_r.rsp.bvalid) begin
      s_nxt.rsp.awready = 1'b1;
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_r.w_got && !s_r.rsp.wready && !s_r.rsp.bvalid) begin
      s_nxt.rsp.wready = 1'b1;
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = axi_req.wdata;
      s_nxt.w_strb = axi_req.wstrb;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.rsp.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = AXI_OKAY;
      unique case (s_r.aw_addr)
        ADDR_CTRL: begin
          nv = ({24'h0, s_r.lo_leg, s_r.hi_leg, 3'h0, s_r.sw_en} & ~wmask) | (s_r.w_data & wmask);
          s_nxt.sw_en = nv[CTRL_SW_EN];
          s_nxt.hi_leg = nv[CTRL_HI_LSB +: 2];
          s_nxt.lo_leg = nv[CTRL_LO_LSB +: 2];
        end
        ADDR_OFFT: begin
          nv = ({16'h0, s_r.cfg.off_cyc} & ~wmask) | (s_r.w_data & wmask);
          s_nxt.cfg.off_cyc = nv[15:0];
        end
        ADDR_DT: begin
          nv = ({24'h0, s_r.cfg.dt_cyc} & ~wmask) | (s_r.w_data & wmask);
          s_nxt.cfg.dt_cyc = nv[7:0];
        end
        ADDR_BLANK: begin
          nv = ({24'h0, s_r.cfg.blank_cyc} & ~wmask) | (s_r.w_data & wmask);
          s_nxt.cfg.blank_cyc = nv[7:0];
        end
        ADDR_MINON: begin
          nv = ({24'h0, s_r.cfg.minon_cyc} & ~wmask) | (s_r.w_data & wmask);
          s_nxt.cfg.minon_cyc = nv[7:0];
        end
        ADDR_STAT: s_nxt.rsp.bresp = AXI_OKAY;
        default: s_nxt.rsp.bresp = AXI_SLVERR;
      endcase
    end
    if (s_r.rsp.bvalid && axi_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_r.rsp.rvalid && !s_r.rsp.arready) begin
      s_nxt.rsp.arready = 1'b1;
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata = rd;
      s_nxt.rsp.rresp = (axi_req.araddr > ADDR_STAT || axi_req.araddr[1:0] != 2'h0) ? AXI_SLVERR : AXI_OKAY;
    end
    if (s_r.rsp.rvalid && axi_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end

    // chopper sequence
    s_nxt.cnt = s_r.cnt + 16'h1;
    if (s_r.on_cnt != 8'hff) begin
      s_nxt.on_cnt = s_r.on_cnt + 8'h1;
    end
    s_nxt.g = '0;
    if (!run) begin
      // disabled or faulted: every switch off
      s_nxt.st = BCCP_OFF;
      s_nxt.cnt = 16'h0;
      s_nxt.trip_pend = 1'b0;
    end else begin
      unique case (s_r.st)
        BCCP_OFF: begin
          // restart conduction
          s_nxt.st = BCCP_ON;
          s_nxt.cnt = 16'h0;
          s_nxt.on_cnt = 8'h0;
          s_nxt.trip_pend = 1'b0;
          s_nxt.g.hi[s_r.hi_leg] = 1'b1;
          s_nxt.g.lo[s_r.lo_leg] = 1'b1;
        end
        BCCP_ON: begin
          s_nxt.g.hi[s_r.hi_leg] = 1'b1;
          s_nxt.g.lo[s_r.lo_leg] = 1'b1;
          // trip after blanking, remembered until minimum
          if (sense_trip && s_r.on_cnt >= s_r.cfg.blank_cyc) begin
            s_nxt.trip_pend = 1'b1;
          end
          if ((s_r.trip_pend || (sense_trip && s_r.on_cnt >= s_r.cfg.blank_cyc))
              && s_r.on_cnt + 8'h1 >= s_r.cfg.minon_cyc) begin
            s_nxt.st = BCCP_DT1;
            s_nxt.g.lo = 3'h0;
            s_nxt.cnt = 16'h0;
            s_nxt.trip_pend = 1'b0;
            s_nxt.trips = s_r.trips + 8'h1;
          end
        end
        BCCP_DT1: begin
          // high side alone, current in upper half
          s_nxt.g.hi[s_r.hi_leg] = 1'b1;
          if (s_r.cnt + 16'h1 >= {8'h0, s_r.cfg.dt_cyc}) begin
            s_nxt.st = BCCP_SYNC;
            s_nxt.g.hi[s_r.lo_leg] = 1'b1;
            s_nxt.cnt = 16'h0;
          end
        end
        BCCP_SYNC: begin
          s_nxt.g.hi[s_r.hi_leg] = 1'b1;
          s_nxt.g.hi[s_r.lo_leg] = 1'b1;
          // off-timer runs from low-side turn-off; time stays fixed even with short on
          if (s_r.cnt + {8'h0, s_r.cfg.dt_cyc} + 16'h1 >= s_r.cfg.off_cyc) begin
            s_nxt.st = BCCP_DT2;
            s_nxt.g.hi[s_r.lo_leg] = 1'b0;
            s_nxt.cnt = 16'h0;
          end
        end
        BCCP_DT2: begin
          s_nxt.g.hi[s_r.hi_leg] = 1'b1;
          if (s_r.cnt + 16'h1 >= {8'h0, s_r.cfg.dt_cyc}) begin
            s_nxt.st = BCCP_ON;
            s_nxt.g.lo[s_r.lo_leg] = 1'b1;
            s_nxt.on_cnt = 8'h0;
            s_nxt.cnt = 16'h0;
          end
        end
        default: s_nxt.st = BCCP_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // register
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= BCCP_OFF;
      s_r.cfg.off_cyc <= OFFT_RST;
      s_r.cfg.dt_cyc <= DT_RST;
      s_r.cfg.blank_cyc <= BLANK_RST;
      s_r.cfg.minon_cyc <= MINON_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // fault pin registered through protect block
  logic fault_oe_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_oe_r <= 1'b1;
    end else begin
      fault_oe_r <= fault_oe;
    end
  end

  assign gates = s_r.g;
  assign axi_rsp = s_r.rsp;
  assign fault_open_drain_output_o = 1'b0;
  assign fault_open_drain_output_oe = fault_oe_r;
endmodule : bccp_top
`default_nettype wire

// ==== tb/bccp_chk_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module bccp_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sense_trip,
  input wire logic ovc_12,
  input wire logic ovc_3,
  input wire logic temp_hi,
  input wire logic temp_lo,
  input wire logic enable_in,
  input wire bccp_pkg::bccp_gate_s gates,
  input wire logic fault_open_drain_output_oe
);
  import bccp_pkg::*;
  logic [15:0] on_r; // low side conduction cycles
  logic [15:0] g_r; // cycles the old gate pattern held
  logic [5:0] prev_r; // gate pattern one cycle back
  logic hit_r; // unmasked trip seen
  logic ovt_r; // overtemperature latch
  logic lo_on;
  assign lo_on = |gates.lo;
  // -------------------------------------------------------
  // helper counters
  // -------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !lo_on) begin
      on_r <= 16'h0;
      hit_r <= 1'b0;
    end else begin
      on_r <= on_r + 16'h1;
      hit_r <= hit_r | (sense_trip && on_r >= 16'(BLANK_CYC));
    end
    prev_r <= aresetn ? gates : 6'h0;
    g_r <= (!aresetn || gates != prev_r) ? 16'h1 : g_r + 16'h1;
    ovt_r <= aresetn && (temp_hi || (ovt_r && temp_lo));
  end
  // -------------------------------------------------------
  // properties
  // -------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_two_legs;
    $countones(gates.hi | gates.lo) <= 2 && (gates.hi & gates.lo) == 3'h0;
  endproperty
  a_two_legs: assert property (p_two_legs) else $error("third leg driven");
  property p_low_first;
    $fell(lo_on) && |gates.hi |-> gates.hi == $past(gates.hi);
  endproperty
  a_low_first: assert property (p_low_first) else $error("high side moved");
  property p_min_on;
    $fell(lo_on) && |gates.hi |-> on_r >= 16'(MIN_ON_CYC);
  endproperty
  a_min_on: assert property (p_min_on) else $error("on too short");
  property p_mask;
    $fell(lo_on) && |gates.hi |-> hit_r;
  endproperty
  a_mask: assert property (p_mask) else $error("masked trip used");
  property p_trip_ends;
    lo_on && sense_trip && on_r >= 16'(MIN_ON_CYC) |-> ##[1:20] !lo_on;
  endproperty
  a_trip_ends: assert property (p_trip_ends) else $error("trip ignored");
  property p_sync_on;
    $countones(gates.hi) == 2 && $countones($past(gates.hi)) == 1 && $past(gates.lo) == 3'h0
      |-> g_r >= 16'(DT_CYC);
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("rectifier early");
  property p_low_back;
    $rose(lo_on) && |$past(gates.hi) |-> $countones($past(gates.hi)) == 1 && g_r >= 16'(DT_CYC);
  endproperty
  a_low_back: assert property (p_low_back) else $error("low side early");
  property p_ocd;
    (ovc_12 || ovc_3) [*5] |-> !fault_open_drain_output_oe;
  endproperty
  a_ocd: assert property (p_ocd) else $error("fault not driven");
  property p_en_off;
    !enable_in [*5] |-> gates == 6'h0;
  endproperty
  a_en_off: assert property (p_en_off) else $error("gates on while disabled");
  property p_release;
    (!ovc_12 && !ovc_3 && !temp_hi && !temp_lo && gates == 6'h0) [*5] |-> fault_open_drain_output_oe;
  endproperty
  a_release: assert property (p_release) else $error("fault not released");
  property p_ovt;
    ovt_r [*3] |-> gates == 6'h0 && !fault_open_drain_output_oe;
  endproperty
  a_ovt: assert property (p_ovt) else $error("overtemp not shut");
endmodule : bccp_chk
bind bccp_top bccp_chk bccp_chk_inst (.aclk(aclk), .aresetn(aresetn), .sense_trip(sense_trip),
  .ovc_12(ovc_12), .ovc_3(ovc_3), .temp_hi(temp_hi), .temp_lo(temp_lo), .enable_in(enable_in),
  .gates(gates), .fault_open_drain_output_oe(fault_open_drain_output_oe));
`default_nettype wire

// ==== tb/bccp_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bccp_bridge_model #(
  parameter int TRIP_LVL = 60,
  parameter int LOCK_CYC = 2500
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bccp_pkg::bccp_gate_s gates,
  input wire logic fault_oe,
  input wire logic en_cmd,
  input wire logic fast,
  output logic sense_trip,
  output logic enable_in
);
  import bccp_pkg::*;
  int cur; // winding current, arbitrary units
  int lock; // enable recharge countdown
  // current grows while a low side conducts, decays slowly otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) cur <= 0;
    else if (|gates.lo) cur <= cur + (fast ? 8 : 1);
    else if (cur > 0) cur <= cur - 1;
  end
  assign sense_trip = cur >= TRIP_LVL;
  // fault line discharges enable, which recharges only after the lockout
  always_ff @(posedge aclk) begin
    if (!aresetn) lock <= 0;
    else if (!fault_oe) lock <= LOCK_CYC;
    else if (lock > 0) lock <= lock - 1;
  end
  assign enable_in = en_cmd && fault_oe && lock == 0;
endmodule : bccp_bridge_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bccp_pkg::*;
  localparam int LOCK = 2500; // 100 us of lockout at 25 MHz
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  bccp_axi_req_s axi_req = '0;
  bccp_axi_rsp_s axi_rsp;
  logic ovc_12 = 1'b0, ovc_3 = 1'b0, temp_hi = 1'b0, temp_lo = 1'b0;
  logic en_cmd = 1'b0, fast = 1'b0, sense_trip, enable_in, f_o, f_oe;
  bccp_gate_s gates;
  logic [31:0] rd_d;
  logic [5:0] pon, pdt, psy;
  logic [5:0] pat[9];
  int fail_count = 0, tests_run = 0, n, h, l, offc, minon;
  int regs[5] = '{0, OFFT_RST, DT_RST, BLANK_RST, MINON_RST}; // register model
  bit r;
  always #20 aclk = ~aclk;
  bccp_top bccp_top_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .sense_trip(sense_trip), .ovc_12(ovc_12), .ovc_3(ovc_3), .temp_hi(temp_hi), .temp_lo(temp_lo),
    .enable_in(enable_in), .gates(gates), .fault_open_drain_output_o(f_o),
    .fault_open_drain_output_oe(f_oe));
  bccp_bridge_model #(.LOCK_CYC(LOCK)) bccp_bridge_model_inst (.aclk(aclk), .aresetn(aresetn),
    .gates(gates), .fault_oe(f_oe), .en_cmd(en_cmd), .fast(fast), .sense_trip(sense_trip),
    .enable_in(enable_in));
  // -------------------------------------------------------
  // check and bus tasks
  // -------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // write one word, holding each channel until its ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    repeat (50) begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) break;
    end
    axi_req.bready <= 1'b0;
    chk("bvalid", axi_rsp.bvalid, 1);
    chk("bresp", axi_rsp.bresp, er);
    @(posedge aclk);
  endtask : wr
  // read one word into rd_d
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    repeat (50) begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) break;
    end
    axi_req.rready <= 1'b0;
    rd_d = axi_rsp.rdata;
    chk("rvalid", axi_rsp.rvalid, 1);
    chk("rresp", axi_rsp.rresp, er);
    @(posedge aclk);
  endtask : rd
  // write a register, update the model, read it back
  task automatic mw(input int i, input int d);
    wr(8'(4 * i), d, AXI_OKAY);
    regs[i] = d;
    rd(8'(4 * i), AXI_OKAY);
    chk("readback", rd_d, regs[i]);
  endtask : mw
  // count cycles until gates (k=0) or fault enable (k=1) show g
  task automatic wait_g(input int k, input logic [5:0] g, output int m);
    m = 0;
    do begin
      @(posedge aclk);
      m++;
    end while ((k ? {5'h0, f_oe} : 6'(gates)) !== g && m < 20000);
    if (m >= 20000) chk("wait", 0, 1);
  endtask : wait_g
  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial begin
    void'($urandom(41864));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), AXI_OKAY);
      chk("reset value", rd_d, regs[i]);
    end
    rd(8'h18, AXI_SLVERR);
    chk("unmapped read", rd_d, 0);
    wr(8'h1c, 32'h5, AXI_SLVERR);
    $display("test registers done");
    en_cmd <= 1'b1;
    for (int p = 0; p < 6; p++) begin
      h = p / 2;
      l = (h + 1 + p % 2) % 3;
      offc = 100 + $urandom % 200;
      minon = 38 + $urandom % 19;
      fast <= p[0];
      // stop the drive before moving legs, so no guard interval is cut short
      mw(0, l << 6 | h << 4);
      mw(1, offc);
      mw(4, minon);
      mw(0, l << 6 | h << 4 | 1);
      pon = {3'(1 << h), 3'(1 << l)};
      pdt = {3'(1 << h), 3'h0};
      psy = {3'(1 << h | 1 << l), 3'h0};
      pat = '{pon, pdt, psy, pdt, pon, pdt, psy, pdt, pon};
      for (int k = 0; k < 9; k++) begin
        wait_g(0, pat[k], n);
        if (k == 5 && p % 2 == 1) chk("forced on", n, minon);
        if (k == 5 && p % 2 == 0) chk("on length", n >= minon, 1);
        if (k == 6) chk("guard", n, DT_CYC);
        if (k == 7) chk("rectify", n >= offc - DT_CYC - 1 && n <= offc - DT_CYC + 1, 1);
        if (k == 8) chk("guard", n, DT_CYC);
      end
    end
    $display("test chopper done");
    en_cmd <= 1'b0;
    wait_g(0, 6'h0, n);
    chk("disable delay", n <= EN_OFF_CYC + 3, 1);
    en_cmd <= 1'b1;
    wait_g(0, pon, n);
    chk("enable delay", n <= EN_ON_CYC + 3, 1);
    $display("test enable done");
    r = $urandom % 2;
    ovc_12 <= r;
    ovc_3 <= !r;
    wait_g(1, 6'h0, n);
    chk("fault delay", n <= OCD_ON_CYC + 3, 1);
    wait_g(0, 6'h0, n);
    chk("switches off", n <= EN_OFF_CYC + 3, 1);
    rd(ADDR_STAT, AXI_OKAY);
    chk("fault status", rd_d[6:4], 3'b010);
    chk("fault level", f_o, 0);
    ovc_12 <= 1'b0;
    ovc_3 <= 1'b0;
    wait_g(1, 6'h1, n);
    chk("fault release", n <= OCD_OFF_CYC + 3, 1);
    wait_g(0, pon, n);
    chk("lockout", n >= LOCK, 1);
    $display("test overcurrent done");
    temp_hi <= 1'b1;
    temp_lo <= 1'b1;
    wait_g(0, 6'h0, n);
    chk("ovt off", n <= 4, 1);
    rd(ADDR_STAT, AXI_OKAY);
    chk("ovt status", rd_d[6:4], 3'b110);
    temp_hi <= 1'b0;
    repeat (30) @(posedge aclk);
    chk("ovt held", {gates, f_oe}, 7'h0);
    temp_lo <= 1'b0;
    wait_g(1, 6'h1, n);
    chk("ovt release", n <= 4, 1);
    wait_g(0, pon, n);
    chk("restart", n >= LOCK, 1);
    $display("test overtemperature done");
    tally_and_finish();
  end
  // watchdog, well beyond the expected run of some 9000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
